/* hdl/smie_pkg.sv */
/*
  Constants, register map, field layouts and state carrier for the
  shift / move / indirect-load execution datapath.
  Assumes a 10 MHz APB clock and a 12-bit APB byte address.
*/
package smie_pkg;

  // Register map, byte addresses
  localparam logic [11:0] SMIE_OFF_CMD       = 12'h000;
  localparam logic [11:0] SMIE_OFF_ACC       = 12'h004;
  localparam logic [11:0] SMIE_OFF_STATUS    = 12'h008;
  localparam logic [11:0] SMIE_OFF_PTR0      = 12'h00C;
  localparam logic [11:0] SMIE_OFF_PTR1      = 12'h010;
  localparam logic [11:0] SMIE_OFF_DATA_BASE = 12'h100;
  localparam logic [11:0] SMIE_OFF_DATA_LAST = 12'h2FC;

  // Status register bit positions
  localparam int unsigned SMIE_STATUS_C_BIT = 0;
  localparam int unsigned SMIE_STATUS_Z_BIT = 1;

  // File space
  localparam int unsigned SMIE_FILE_DEPTH = 128;
  localparam logic [6:0]  SMIE_WINDOW0    = 7'h00;
  localparam logic [6:0]  SMIE_WINDOW1    = 7'h01;
  localparam logic        SMIE_DEST_ACC   = 1'b0;
  localparam logic [15:0] SMIE_PTR_STEP   = 16'h0001;
  localparam logic [7:0]  SMIE_ZERO_BYTE  = 8'h00;
  localparam logic [31:0] SMIE_ZERO_WORD  = 32'h0000_0000;
  localparam logic [15:0] SMIE_PTR_RESET  = 16'h0000;
  localparam logic [7:0]  SMIE_ACC_RESET  = 8'h00;

  typedef enum logic [1:0] {
    SMIE_OP_NOP   = 2'h0,
    SMIE_OP_SHIFT = 2'h1,
    SMIE_OP_MOVE  = 2'h2,
    SMIE_OP_ILOAD = 2'h3
  } smie_op_e;

  typedef enum logic [1:0] {
    SMIE_MODE_PRE_INC  = 2'h0,
    SMIE_MODE_PRE_DEC  = 2'h1,
    SMIE_MODE_POST_INC = 2'h2,
    SMIE_MODE_POST_DEC = 2'h3
  } smie_mode_e;

  // Command word written to SMIE_OFF_CMD
  typedef struct packed {
    logic [9:0] rsv_hi;
    logic [5:0] offset;
    logic       rsv_file;
    logic [6:0] file;
    logic       rsv_mode;
    smie_mode_e pointer_update_mode;
    logic       rel;
    logic       ptr_sel;
    logic       dest;
    smie_op_e   op;
  } smie_cmd_s;

  typedef struct packed {
    logic [SMIE_FILE_DEPTH-1:0][7:0] mem;
    logic [1:0][15:0]                pointer_register;
    logic [7:0]                      acc;
    logic                            carry;
    logic                            zero;
    smie_cmd_s                       last_cmd;
    logic                            pready;
    logic                            pslverr;
    logic [31:0]                     prdata;
  } smie_state_s;

endpackage

/* hdl/smie_exec.sv */
/*
  Execution datapath for logical right shift, move-file and indirect
  load, with its registers and a 128-byte file store behind APB.
  Assumes an APB3 master on pclk; no other agent touches the file store.
*/
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module smie_exec
  import smie_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  smie_state_s state_reg;
  smie_state_s state_next;

  smie_cmd_s   cmd;
  logic        win_hit;
  logic [6:0]  file_idx;
  logic [7:0]  file_val;
  logic [7:0]  shift_val;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_ea;
  logic [15:0] ptr_new;
  logic [15:0] ofs_ext;
  logic [11:0] data_diff;
  logic        data_hit;
  logic [6:0]  data_idx;
  logic        bus_done;
  logic [31:0] rd_val;
  logic        rd_err;

  // Command decode and operand fetch
  always_comb begin
    cmd       = smie_cmd_s'(pwdata);
    win_hit   = (cmd.file == SMIE_WINDOW0) || (cmd.file == SMIE_WINDOW1);
    // Window slot has no storage: use its pointer, low bits index the store
    file_idx  = win_hit ? state_reg.pointer_register[cmd.file[0]][6:0] : cmd.file;
    file_val  = state_reg.mem[file_idx];
    shift_val = {1'b0, file_val[7:1]};
    ptr_cur   = state_reg.pointer_register[cmd.ptr_sel];
    ptr_inc   = ptr_cur + SMIE_PTR_STEP;
    ptr_dec   = ptr_cur - SMIE_PTR_STEP;
    ofs_ext   = {{10{cmd.offset[5]}}, cmd.offset};
    if (cmd.rel) begin
      ptr_ea  = ptr_cur + ofs_ext;
      ptr_new = ptr_cur;
    end else begin
      unique case (cmd.pointer_update_mode)
        SMIE_MODE_PRE_INC: begin
          ptr_ea  = ptr_inc;
          ptr_new = ptr_inc;
        end
        SMIE_MODE_PRE_DEC: begin
          ptr_ea  = ptr_dec;
          ptr_new = ptr_dec;
        end
        SMIE_MODE_POST_INC: begin
          ptr_ea  = ptr_cur;
          ptr_new = ptr_inc;
        end
        SMIE_MODE_POST_DEC: begin
          ptr_ea  = ptr_cur;
          ptr_new = ptr_dec;
        end
      endcase
    end
  end

  // Address decode and read mux
  always_comb begin
    data_diff = paddr - SMIE_OFF_DATA_BASE;
    data_hit  = (paddr >= SMIE_OFF_DATA_BASE) && (paddr <= SMIE_OFF_DATA_LAST) && (paddr[1:0] == 2'h0);
    data_idx  = data_diff[8:2];
    rd_val    = SMIE_ZERO_WORD;
    rd_err    = 1'b0;
    if (data_hit) begin
      rd_val[7:0] = state_reg.mem[data_idx];
    end else begin
      unique case (paddr)
        SMIE_OFF_CMD:    rd_val = state_reg.last_cmd;
        SMIE_OFF_ACC:    rd_val[7:0] = state_reg.acc;
        SMIE_OFF_STATUS: begin
          rd_val[SMIE_STATUS_C_BIT] = state_reg.carry;
          rd_val[SMIE_STATUS_Z_BIT] = state_reg.zero;
        end
        SMIE_OFF_PTR0:   rd_val[15:0] = state_reg.pointer_register[0];
        SMIE_OFF_PTR1:   rd_val[15:0] = state_reg.pointer_register[1];
        default:         rd_err = 1'b1;
      endcase
    end
  end

  // Second access cycle completes the transfer; writes land only here
  assign bus_done = psel && penable && state_reg.pready;

  always_comb begin
    state_next         = state_reg;
    state_next.pready  = psel && penable && !state_reg.pready;
    state_next.pslverr = 1'b0;
    if (psel && penable && !state_reg.pready) begin
      state_next.prdata  = pwrite ? SMIE_ZERO_WORD : rd_val;
      state_next.pslverr = rd_err;
    end
    if (bus_done && pwrite && !rd_err) begin
      if (data_hit) begin
        state_next.mem[data_idx] = pwdata[7:0];
      end else begin
        unique case (paddr)
          SMIE_OFF_ACC:    state_next.acc = pwdata[7:0];
          SMIE_OFF_STATUS: begin
            state_next.carry = pwdata[SMIE_STATUS_C_BIT];
            state_next.zero  = pwdata[SMIE_STATUS_Z_BIT];
          end
          SMIE_OFF_PTR0:   state_next.pointer_register[0] = pwdata[15:0];
          SMIE_OFF_PTR1:   state_next.pointer_register[1] = pwdata[15:0];
          SMIE_OFF_CMD: begin
            // Whole instruction retires on this one edge
            state_next.last_cmd = cmd;
            unique case (cmd.op)
              SMIE_OP_NOP: begin
              end
              SMIE_OP_SHIFT: begin
                state_next.carry = file_val[0];
                state_next.zero  = (shift_val == SMIE_ZERO_BYTE);
                if (cmd.dest == SMIE_DEST_ACC) begin
                  state_next.acc = shift_val;
                end else begin
                  state_next.mem[file_idx] = shift_val;
                end
              end
              SMIE_OP_MOVE: begin
                state_next.zero = (file_val == SMIE_ZERO_BYTE);
                if (cmd.dest == SMIE_DEST_ACC) begin
                  state_next.acc = file_val;
                end else begin
                  state_next.mem[file_idx] = file_val;
                end
              end
              SMIE_OP_ILOAD: begin
                // Carry is left alone: pointer arithmetic sets no flag
                state_next.acc  = state_reg.mem[ptr_ea[6:0]];
                state_next.zero = (state_reg.mem[ptr_ea[6:0]] == SMIE_ZERO_BYTE);
                state_next.pointer_register[cmd.ptr_sel] = ptr_new;
              end
            endcase
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{mem: '0, pointer_register: {SMIE_PTR_RESET, SMIE_PTR_RESET}, acc: SMIE_ACC_RESET,
                     carry: 1'b0, zero: 1'b0, last_cmd: '0, pready: 1'b0, pslverr: 1'b0,
                     prdata: SMIE_ZERO_WORD};
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata  = state_reg.prdata;
  assign pready  = state_reg.pready;
  assign pslverr = state_reg.pslverr;

endmodule // smie_exec

/* tb/smie_exec_properties.sv */
/*
  Checker for the smie_exec APB port: handshake timing and field widths.
  Assumes it is bound to smie_exec by the statement at its foot.
*/
`timescale 1ns/1ps
module smie_exec_properties
  import smie_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  wire rd = pready && !pwrite;
  wire infile = paddr >= SMIE_OFF_DATA_BASE && paddr <= SMIE_OFF_DATA_LAST;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_phase; pready |-> psel && penable; endproperty
  a_phase: assert property (p_phase) else $error("pready outside access");
  property p_file; pready && infile && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_file: assert property (p_file) else $error("file byte refused");
  property p_acc; rd && paddr == SMIE_OFF_ACC |-> prdata[31:8] == 24'h000000; endproperty
  a_acc: assert property (p_acc) else $error("acc wider than a byte");
  property p_ptr; rd && (paddr == SMIE_OFF_PTR0 || paddr == SMIE_OFF_PTR1) |-> prdata[31:16] == 16'h0000; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer wider than 16 bits");
  property p_dat; rd && infile |-> prdata[31:8] == 24'h000000; endproperty
  a_dat: assert property (p_dat) else $error("file byte too wide");
  property p_stat; rd && paddr == SMIE_OFF_STATUS |-> prdata[31:2] == 30'h00000000; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
endmodule // smie_exec_properties

bind smie_exec smie_exec_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* tb/smie_exec_bench.sv */
/*
  Self-checking bench for smie_exec: APB tasks issue shift, move and
  indirect-load commands and read the results back.
  Assumes the property checker is bound in from its own file.
*/
`timescale 1ns/1ps
module smie_exec_bench
  import smie_pkg::*;
;
  localparam logic [11:0] CM = SMIE_OFF_CMD, AC = SMIE_OFF_ACC, ST = SMIE_OFF_STATUS;
  localparam logic [11:0] P0 = SMIE_OFF_PTR0, P1 = SMIE_OFF_PTR1, DB = SMIE_OFF_DATA_BASE;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd, prdata;
  logic        pready, pslverr;
  logic [6:0]  ea;
  int          miscompares = 0, compares = 0;

  always #50 pclk = ~pclk;

  smie_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] cmd(input logic [1:0] op, input logic d, s, r, input logic [1:0] m,
                                      input logic [6:0] f, input logic [5:0] o);
    return {10'h000, o, 1'b0, f, 1'b0, m, r, s, d, op};
  endfunction
  // Fill pattern of file bytes; bytes 0 and 1 stay zero from reset
  function automatic logic [7:0] val(input logic [6:0] i);
    return {1'b0, i} + 8'h40;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, got);
    compares++;
    if (got !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h00000001, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    chk(nm, ex, r);
  endtask
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs about 750 cycles
  initial begin
    #2_000_000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc("ptr0", P0, 32'h00000000);
    for (int i = 2; i < 128; i++) wr(DB + 12'(4 * i), {24'h000000, val(7'(i))});
    wr(CM, cmd(SMIE_OP_SHIFT, 1'b0, 1'b0, 1'b0, 2'h0, 7'h05, 6'h00));
    rc("shift_acc", AC, 32'h00000022);
    rc("shift_c", ST, 32'h00000001);
    wr(DB + 12'h018, 32'h00000001);
    wr(CM, cmd(SMIE_OP_SHIFT, 1'b1, 1'b0, 1'b0, 2'h0, 7'h06, 6'h00));
    rc("shift_file", DB + 12'h018, 32'h00000000);
    rc("shift_z", ST, 32'h00000003);
    rc("acc_kept", AC, 32'h00000022);
    $display("test shift done");
    wr(CM, cmd(SMIE_OP_MOVE, 1'b0, 1'b0, 1'b0, 2'h0, 7'h06, 6'h00));
    rc("move_acc", AC, 32'h00000000);
    rc("move_z", ST, 32'h00000003);
    wr(CM, cmd(SMIE_OP_MOVE, 1'b1, 1'b0, 1'b0, 2'h0, 7'h07, 6'h00));
    rc("move_self", DB + 12'h01C, 32'h00000047);
    rc("move_self_z", ST, 32'h00000001);
    wr(P0, 32'h00000007);
    wr(CM, cmd(SMIE_OP_MOVE, 1'b0, 1'b0, 1'b0, 2'h0, SMIE_WINDOW0, 6'h00));
    rc("window", AC, 32'h00000047);
    $display("test move done");
    for (int m = 0; m < 4; m++) begin
      wr(P1, 32'h00000010);
      wr(ST, 32'h00000001);
      wr(CM, cmd(SMIE_OP_ILOAD, 1'b0, 1'b1, 1'b0, 2'(m), 7'h00, 6'h00));
      ea = (m == 0) ? 7'h11 : (m == 1) ? 7'h0F : 7'h10;
      rc("iload_acc", AC, {24'h000000, val(ea)});
      rc("iload_ptr", P1, m[0] ? 32'h0000000F : 32'h00000011);
      rc("iload_st", ST, 32'h00000001);
    end
    rc("ptr0_idle", P0, 32'h00000007);
    wr(P0, 32'h00000020);
    wr(CM, cmd(SMIE_OP_ILOAD, 1'b0, 1'b0, 1'b1, 2'h3, 7'h00, 6'h20));
    rc("rel_acc", AC, 32'h00000000);
    rc("rel_z", ST, 32'h00000003);
    wr(CM, cmd(SMIE_OP_ILOAD, 1'b0, 1'b0, 1'b1, 2'h0, 7'h00, 6'h1F));
    rc("rel_hi", AC, 32'h0000007F);
    rc("rel_ptr", P0, 32'h00000020);
    wr(P0, 32'h00000000);
    wr(CM, cmd(SMIE_OP_ILOAD, 1'b0, 1'b0, 1'b0, 2'h1, 7'h00, 6'h00));
    rc("wrap_dn", P0, 32'h0000FFFF);
    rc("wrap_acc", AC, 32'h000000BF);
    wr(CM, cmd(SMIE_OP_ILOAD, 1'b0, 1'b0, 1'b0, 2'h2, 7'h00, 6'h00));
    rc("wrap_up", P0, 32'h00000000);
    // No-op must only latch the command word and leave the datapath alone
    wr(CM, cmd(SMIE_OP_NOP, 1'b1, 1'b0, 1'b0, 2'h0, 7'h09, 6'h00));
    rc("nop_cmd", CM, 32'h00000904);
    rc("nop_acc", AC, 32'h000000BF);
    xfer(1'b0, 12'h020, 32'h00000000, rd, er);
    chk("unmapped", 32'h00000001, {31'h0, er});
    $display("test iload done");
    wrap_up();
  end
endmodule // smie_exec_bench
